// >>> src/cjlx_core.sv
// Execution core: arithmetic on one register, register jumps, moves, byte and code loads
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE_01: Complement mode 00 inverts, 01 inverts plus one, 10 inverts plus test flag.
// RULE_02: Plain inverse sets test flag on zero; adding modes put carry in it.
// RULE_03: Complement into register 6 or 7 loads the matching zero flag.
// RULE_04: Carry-decrement writes reg minus one plus test flag; carry, overflow, zero flags.
// RULE_05: Decrement-and-test subtracts one, test flag on zero, overflow and zero flags.
// RULE_06: Sign-widen copies bit 7 into the upper byte; zero flag for 6 or 7.
// RULE_07: Carry-increment adds test flag; carry, overflow and zero flags updated.
// RULE_08: Register jump mode 00 jumps on false, 01 on true, 10 always.
// RULE_09: Jump mode 11 writes return address into link register, then jumps.
// RULE_10: No delay slot; the word fetched after a taken jump is squashed.
// RULE_11: Word move and address-register move; only word move touches zero flags.
// RULE_12: Short immediate fills low byte, clears high byte, updates zero flag.
// RULE_13: Instructions carrying a second word take two fetch cycles.
// RULE_14: Large immediate takes low 16 bits from second word, top from first.
// RULE_15: Extension to data register zero-extends; into extension keeps low six bits.
// RULE_16: Short byte transfer uses address register plus four-bit displacement.
// RULE_17: Long byte transfer adds the sixteen-bit second word to address register.
// RULE_18: Indexed byte transfer adds a general register to the address register.
// RULE_19: Single-word byte transfer uses base pointer plus eight bits, register zero.
// RULE_20: Code-fetch load reads program memory at an address register.
// RULE_21: With test flag clear, invert-plus-flag equals plain inverse.
// RULE_22: Byte store writes low byte; byte load fills register from the byte.
// RULE_23: Flags not named by an operation keep their values.
module cjlx_core import cjlx_pkg::*; (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// Program memory read port, data one cycle after the strobe
	output logic [ADDR_W-1:0] pm_addr_out,
	output logic pm_rd_out,
	input wire logic [DATA_W-1:0] pm_data_in,
	// Data memory byte port, read data one cycle after the strobe
	output logic [ADDR_W-1:0] dm_addr_out,
	output logic dm_rd_out,
	output logic dm_wr_out,
	output logic [7:0] dm_wdata_out,
	input wire logic [7:0] dm_rdata_in,
	// Core status
	output logic [ADDR_W-1:0] pc_out,
	output logic squash_out,
	output logic retire_out,
	output logic t_flag_out,
	output logic v_flag_out,
	output logic r6_zero_flag_out,
	output logic r7_zero_flag_out
);
	cjlx_state_t state_r, state_nxt;
	logic [DATA_W-1:0] gpr_r [NUM_GPR];
	logic [EXT_W-1:0] ext_r [NUM_AREG];
	logic [ADDR_W-1:0] areg_w [NUM_AREG];
	logic [DATA_W-1:0] ir_r, ir_nxt, imm_r, imm_nxt, pf_word_r, pf_nxt, word_w;
	logic use_pf_r, use_pf_nxt, ld_pend_r, ld_pend_nxt, ld_code_r, ld_code_nxt;
	logic [3:0] ld_idx_r, ld_idx_nxt;
	logic [ADDR_W-1:0] pc_r, pc_nxt, pm_addr_r, pm_addr_nxt, dm_addr_r, dm_addr_nxt;
	logic pm_rd_r, pm_rd_nxt, dm_rd_r, dm_rd_nxt, dm_wr_r, dm_wr_nxt;
	logic [7:0] dm_wdata_r, dm_wdata_nxt;
	logic squash_r, squash_nxt, retire_r, retire_nxt;
	logic t_r, v_r, z0_r, z1_r;

	// Registered outputs
	assign pm_addr_out = pm_addr_r;
	assign pm_rd_out = pm_rd_r;
	assign dm_addr_out = dm_addr_r;
	assign dm_rd_out = dm_rd_r;
	assign dm_wr_out = dm_wr_r;
	assign dm_wdata_out = dm_wdata_r;
	assign pc_out = pc_r;
	assign squash_out = squash_r;
	assign retire_out = retire_r;
	assign t_flag_out = t_r;
	assign v_flag_out = v_r;
	assign r6_zero_flag_out = z0_r;
	assign r7_zero_flag_out = z1_r;

	// Address registers are the upper eight general registers with their extensions
	for (genvar g = 0; g < NUM_AREG; g++) begin : g_areg
		assign areg_w[g] = {ext_r[g], gpr_r[g+8]};
	end

	// Word being decoded: a fetch parked during a memory op, or straight from memory
	logic two_word_w;
	assign word_w = use_pf_r ? pf_word_r : pm_data_in;
	assign two_word_w = ((word_w & OPM_LDI16) == OPV_LDI16) | ((word_w & OPM_LDA22) == OPV_LDA22)
		| ((word_w & OPM_LDB_L) == OPV_LDB_L); // [RULE_13]

	// Instruction class decode
	logic is_com, is_decrement_carry_op, is_dt, is_ext, is_increment_carry_op, is_jmp, is_mov, is_mova, is_rext;
	logic is_ldi8, is_ldi16, is_lda22, is_ldb_s, is_ldb_x, is_ldb_l, is_ldb_8, is_ldc;
	logic is_alu, is_ldb, is_long;
	assign is_com = (ir_r & OPM_COM) == OPV_COM;
	assign is_decrement_carry_op = (ir_r & OPM_ONE) == OPV_DECREMENT_CARRY_OP;
	assign is_increment_carry_op = (ir_r & OPM_ONE) == OPV_INCREMENT_CARRY_OP;
	assign is_ext = (ir_r & OPM_ONE) == OPV_EXT;
	assign is_dt = (ir_r & OPM_ONE) == OPV_DT;
	assign is_jmp = (ir_r & OPM_JMP) == OPV_JMP;
	assign is_mov = (ir_r & OPM_MOV) == OPV_MOV;
	assign is_mova = (ir_r & OPM_MOVA) == OPV_MOVA;
	assign is_rext = (ir_r & OPM_REXT) == OPV_REXT;
	assign is_ldi8 = (ir_r & OPM_LDI8) == OPV_LDI8;
	assign is_ldi16 = (ir_r & OPM_LDI16) == OPV_LDI16;
	assign is_lda22 = (ir_r & OPM_LDA22) == OPV_LDA22;
	assign is_ldb_s = (ir_r & OPM_LDB_S) == OPV_LDB_S;
	assign is_ldb_x = (ir_r & OPM_LDB_S) == OPV_LDB_X;
	assign is_ldb_l = (ir_r & OPM_LDB_L) == OPV_LDB_L;
	assign is_ldb_8 = (ir_r & OPM_LDB_8) == OPV_LDB_8;
	assign is_ldc = (ir_r & OPM_LDC) == OPV_LDC;
	// Complement mode 11 is not defined and executes as a no-operation
	assign is_alu = (is_com & (ir_r[5:4] != 2'h3)) | is_decrement_carry_op | is_dt | is_ext | is_increment_carry_op;
	assign is_ldb = is_ldb_s | is_ldb_x | is_ldb_l | is_ldb_8;
	assign is_long = is_ldi16 | is_lda22 | is_ldb_l;

	// Operand fields
	logic [3:0] rn_alu, rn_hi, dn, ldb_reg_w;
	logic [2:0] ai_lo, ai_mid;
	assign rn_alu = ir_r[3:0];
	assign rn_hi = ir_r[11:8];
	assign dn = {1'b0, ir_r[10:8]};
	assign ai_lo = ir_r[2:0];
	assign ai_mid = ir_r[6:4];

	// Arithmetic unit
	logic [2:0] alu_op_w;
	logic [DATA_W-1:0] alu_opnd_w, alu_res_w;
	logic alu_t_w, alu_v_w;
	assign alu_op_w = is_com ? ALU_COM : is_decrement_carry_op ? ALU_DECREMENT_CARRY_OP : is_dt ? ALU_DT : is_ext ? ALU_EXT : ALU_INCREMENT_CARRY_OP;
	assign alu_opnd_w = gpr_r[rn_alu];
	cjlx_alu u_alu (
		.op_in(alu_op_w),
		.com_mode_in(ir_r[5:4]), // [RULE_01]
		.opnd_in(alu_opnd_w),
		.t_in(t_r),
		.res_out(alu_res_w),
		.t_out(alu_t_w),
		.v_out(alu_v_w)
	);

	// Jump condition and targets
	logic [1:0] jmp_mode_w;
	logic jmp_take_w, jmp_link_w;
	logic [ADDR_W-1:0] jmp_target_w, link_val_w, pc_step_w;
	assign jmp_mode_w = {ir_r[8], ir_r[3]};
	assign jmp_take_w = is_jmp & ((jmp_mode_w == JMP_IF_FALSE & ~t_r) | (jmp_mode_w == JMP_IF_TRUE & t_r)
		| (jmp_mode_w == JMP_ALWAYS) | (jmp_mode_w == JMP_LINK)); // [RULE_08]
	assign jmp_link_w = is_jmp & (jmp_mode_w == JMP_LINK);
	assign jmp_target_w = areg_w[ai_lo];
	assign link_val_w = pc_r + INSTR_BYTES; // [RULE_09]
	assign pc_step_w = is_long ? pc_r + INSTR_BYTES + INSTR_BYTES : pc_r + INSTR_BYTES;

	// Byte transfer address, direction and data register
	logic [ADDR_W-1:0] ldb_addr_w;
	logic ldb_dir_w;
	assign ldb_addr_w = is_ldb_8 ? areg_w[BASE8_AREG] + {14'h0000, ir_r[7:0]} // [RULE_19]
		: is_ldb_l ? areg_w[ai_lo] + {6'h00, imm_r} // [RULE_17]
		: is_ldb_x ? areg_w[ai_mid] + {6'h00, gpr_r[ir_r[3:0]]} // [RULE_18]
		: areg_w[ai_mid] + {18'h00000, ir_r[3:0]}; // [RULE_16]
	assign ldb_dir_w = is_ldb_8 ? ir_r[8] : is_ldb_l ? ir_r[3] : ir_r[12];
	assign ldb_reg_w = is_ldb_8 ? REG_ZERO : dn; // [RULE_19]

	// Write-back selection for single-cycle instructions
	logic gw_en, ew_en, zf_en;
	logic [3:0] gw_idx;
	logic [2:0] ew_idx;
	logic [DATA_W-1:0] gw_data;
	logic [EXT_W-1:0] ew_data;
	always_comb begin
		gw_en = 1'b0;
		ew_en = 1'b0;
		zf_en = 1'b0;
		gw_idx = rn_hi;
		ew_idx = ir_r[2:0];
		gw_data = imm_r;
		ew_data = gpr_r[dn][EXT_W-1:0];
		if (is_alu) begin
			gw_en = 1'b1;
			zf_en = 1'b1; // [RULE_03]
			gw_idx = rn_alu;
			gw_data = alu_res_w;
		end else if (is_mov) begin
			gw_en = 1'b1;
			zf_en = 1'b1; // [RULE_11]
			gw_data = gpr_r[ir_r[3:0]];
		end else if (is_mova) begin
			gw_en = 1'b1;
			ew_en = 1'b1; // [RULE_11]
			gw_idx = {1'b1, ir_r[10:8]};
			ew_idx = ir_r[10:8];
			gw_data = jmp_target_w[DATA_W-1:0];
			ew_data = jmp_target_w[ADDR_W-1:DATA_W];
		end else if (is_rext) begin
			gw_en = ~ir_r[3];
			ew_en = ir_r[3]; // [RULE_15]
			gw_idx = dn;
			gw_data = {10'h000, ext_r[ir_r[2:0]]};
		end else if (is_ldi8) begin
			gw_en = 1'b1;
			zf_en = 1'b1;
			gw_data = {8'h00, ir_r[7:0]}; // [RULE_12]
		end else if (is_ldi16) begin
			gw_en = 1'b1;
			zf_en = 1'b1;
		end else if (is_lda22) begin
			gw_en = 1'b1;
			ew_en = 1'b1;
			gw_idx = {1'b1, ir_r[11:9]};
			ew_idx = ir_r[11:9];
			ew_data = ir_r[5:0]; // [RULE_14]
		end else if (jmp_link_w) begin
			gw_en = 1'b1;
			ew_en = 1'b1;
			gw_idx = {1'b1, LINK_AREG};
			ew_idx = LINK_AREG;
			gw_data = link_val_w[DATA_W-1:0];
			ew_data = link_val_w[ADDR_W-1:DATA_W];
		end
	end

	// Sequencer: the next word is always prefetched while an instruction executes
	always_comb begin
		state_nxt = state_r;
		pc_nxt = pc_r;
		ir_nxt = ir_r;
		imm_nxt = imm_r;
		pf_nxt = pf_word_r;
		use_pf_nxt = use_pf_r;
		ld_pend_nxt = 1'b0;
		ld_code_nxt = ld_code_r;
		ld_idx_nxt = ld_idx_r;
		pm_rd_nxt = 1'b0;
		pm_addr_nxt = pm_addr_r;
		dm_rd_nxt = 1'b0;
		dm_wr_nxt = 1'b0;
		dm_addr_nxt = dm_addr_r;
		dm_wdata_nxt = dm_wdata_r;
		squash_nxt = 1'b0;
		retire_nxt = 1'b0;
		case (state_r)
			ST_FETCH: begin
				pm_rd_nxt = 1'b1;
				pm_addr_nxt = pc_r;
				state_nxt = ST_FWAIT;
			end
			ST_FWAIT: state_nxt = ST_DECODE;
			ST_DECODE: begin
				ir_nxt = word_w;
				use_pf_nxt = 1'b0;
				pm_rd_nxt = 1'b1;
				pm_addr_nxt = pc_r + INSTR_BYTES;
				state_nxt = two_word_w ? ST_XWAIT : ST_EXEC; // [RULE_13]
			end
			ST_XWAIT: state_nxt = ST_XCAP;
			ST_XCAP: begin
				imm_nxt = pm_data_in;
				pm_rd_nxt = 1'b1;
				pm_addr_nxt = pc_r + INSTR_BYTES + INSTR_BYTES;
				state_nxt = ST_EXEC;
			end
			ST_EXEC: begin
				if (jmp_take_w) begin
					// The prefetched following word lands in the wait cycle and is dropped [RULE_10]
					pc_nxt = jmp_target_w;
					squash_nxt = 1'b1;
					retire_nxt = 1'b1;
					pm_rd_nxt = 1'b1;
					pm_addr_nxt = jmp_target_w;
					state_nxt = ST_FWAIT;
				end else if (is_ldb) begin
					dm_rd_nxt = ldb_dir_w != DIR_STORE;
					dm_wr_nxt = ldb_dir_w == DIR_STORE;
					dm_addr_nxt = ldb_addr_w;
					dm_wdata_nxt = gpr_r[ldb_reg_w][7:0]; // [RULE_22]
					ld_pend_nxt = ldb_dir_w != DIR_STORE;
					ld_code_nxt = 1'b0;
					ld_idx_nxt = ldb_reg_w;
					state_nxt = ST_MWAIT;
				end else if (is_ldc) begin
					pm_rd_nxt = 1'b1;
					pm_addr_nxt = areg_w[ai_lo]; // [RULE_20]
					ld_pend_nxt = 1'b1;
					ld_code_nxt = 1'b1;
					ld_idx_nxt = rn_hi;
					state_nxt = ST_MWAIT;
				end else begin
					pc_nxt = pc_step_w;
					retire_nxt = 1'b1;
					state_nxt = ST_DECODE;
				end
			end
			ST_MWAIT: begin
				// Park the prefetched word while the memory answer is still due
				pf_nxt = pm_data_in;
				use_pf_nxt = 1'b1;
				ld_pend_nxt = ld_pend_r;
				state_nxt = ST_MCAP;
			end
			ST_MCAP: begin
				pc_nxt = pc_step_w;
				retire_nxt = 1'b1;
				state_nxt = ST_DECODE;
			end
			default: state_nxt = ST_FETCH;
		endcase
	end

	// Sequencer and port registers
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			state_r <= ST_FETCH;
			pc_r <= RESET_PC;
			ir_r <= 16'h0000;
			imm_r <= 16'h0000;
			pf_word_r <= 16'h0000;
			use_pf_r <= 1'b0;
			ld_pend_r <= 1'b0;
			ld_code_r <= 1'b0;
			ld_idx_r <= 4'h0;
			pm_rd_r <= 1'b0;
			pm_addr_r <= RESET_PC;
			dm_rd_r <= 1'b0;
			dm_wr_r <= 1'b0;
			dm_addr_r <= 22'h000000;
			dm_wdata_r <= 8'h00;
			squash_r <= 1'b0;
			retire_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			pc_r <= pc_nxt;
			ir_r <= ir_nxt;
			imm_r <= imm_nxt;
			pf_word_r <= pf_nxt;
			use_pf_r <= use_pf_nxt;
			ld_pend_r <= ld_pend_nxt;
			ld_code_r <= ld_code_nxt;
			ld_idx_r <= ld_idx_nxt;
			pm_rd_r <= pm_rd_nxt;
			pm_addr_r <= pm_addr_nxt;
			dm_rd_r <= dm_rd_nxt;
			dm_wr_r <= dm_wr_nxt;
			dm_addr_r <= dm_addr_nxt;
			dm_wdata_r <= dm_wdata_nxt;
			squash_r <= squash_nxt;
			retire_r <= retire_nxt;
		end
	end

	// Register file; loads write in the capture cycle, everything else at execute
	logic exec_w, load_wr_w;
	logic [DATA_W-1:0] load_data_w;
	assign exec_w = state_r == ST_EXEC;
	assign load_wr_w = (state_r == ST_MCAP) & ld_pend_r;
	assign load_data_w = ld_code_r ? pm_data_in : {8'h00, dm_rdata_in}; // [RULE_20] [RULE_22]
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < NUM_GPR; i++) gpr_r[i] <= 16'h0000;
			for (int i = 0; i < NUM_AREG; i++) ext_r[i] <= 6'h00;
		end else if (exec_w) begin
			if (gw_en) gpr_r[gw_idx] <= gw_data;
			if (ew_en) ext_r[ew_idx] <= ew_data;
		end else if (load_wr_w) begin
			gpr_r[ld_idx_r] <= load_data_w;
		end
	end

	// Flags change only when the executing operation names them
	logic zf_hit_w;
	assign zf_hit_w = exec_w & gw_en & zf_en;
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			t_r <= 1'b0;
			v_r <= 1'b0;
			z0_r <= 1'b0;
			z1_r <= 1'b0;
		end else begin
			if (exec_w & is_alu) t_r <= alu_t_w; // [RULE_02] [RULE_23]
			if (exec_w & (is_decrement_carry_op | is_dt | is_increment_carry_op)) v_r <= alu_v_w; // [RULE_04] [RULE_05] [RULE_07]
			if (zf_hit_w & (gw_idx == ZREG_LO)) z0_r <= (gw_data == 16'h0000); // [RULE_03] [RULE_12]
			if (zf_hit_w & (gw_idx == ZREG_HI)) z1_r <= (gw_data == 16'h0000);
		end
	end

	// Checks on the decode and execute stages
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);

	a_com_invert: assert property ( // [RULE_01]
		exec_w && is_com && ir_r[5:4] == COM_INV |=> gpr_r[$past(rn_alu)] == ~$past(alu_opnd_w)
		&& t_r == ($past(alu_opnd_w) == 16'hffff))
		else $error("plain inverse result or test flag wrong");
	a_negc_clear_t: assert property ( // [RULE_21]
		exec_w && is_com && ir_r[5:4] == COM_NEGC && !t_r |=> gpr_r[$past(rn_alu)] == ~$past(alu_opnd_w))
		else $error("invert plus clear flag differs from plain inverse");
	a_zero_r6_flag: assert property ( // [RULE_03]
		exec_w && is_alu && rn_alu == ZREG_LO |=> z0_r == (gpr_r[6] == 16'h0000))
		else $error("r6 zero flag not loaded from result");
	a_dt_test_zero: assert property ( // [RULE_05]
		exec_w && is_dt |=> t_r == (gpr_r[$past(rn_alu)] == 16'h0000) && gpr_r[$past(rn_alu)] == $past(alu_opnd_w) - 16'h0001)
		else $error("decrement and test result wrong");
	a_sign_widen: assert property ( // [RULE_06]
		exec_w && is_ext |=> gpr_r[$past(rn_alu)][15:8] == {8{$past(alu_opnd_w[7])}})
		else $error("sign widen upper byte wrong");
	a_jump_squash: assert property ( // [RULE_10]
		exec_w && jmp_take_w |=> squash_out && pc_r == $past(jmp_target_w) && pm_addr_r == pc_r ##1 !squash_out)
		else $error("taken jump did not squash and redirect");
	a_jump_not_taken: assert property ( // [RULE_08]
		exec_w && is_jmp && !jmp_take_w |=> !squash_out && pc_r == $past(pc_r) + INSTR_BYTES)
		else $error("untaken jump changed flow");
	a_link_write: assert property ( // [RULE_09]
		exec_w && jmp_link_w |=> {ext_r[6], gpr_r[14]} == $past(pc_r) + INSTR_BYTES)
		else $error("link register not loaded with return address");
	a_two_fetch: assert property ( // [RULE_13]
		state_r == ST_DECODE && two_word_w |=> state_r == ST_XWAIT ##1 state_r == ST_XCAP ##1 state_r == ST_EXEC)
		else $error("second word not fetched");
	a_byte_store: assert property ( // [RULE_22]
		exec_w && is_ldb && ldb_dir_w == DIR_STORE |=> dm_wr_out && !dm_rd_out
		&& dm_addr_out == $past(ldb_addr_w) && dm_wdata_out == $past(gpr_r[ldb_reg_w][7:0]))
		else $error("byte store address or data wrong");
	a_short_imm: assert property ( // [RULE_12]
		exec_w && is_ldi8 |=> gpr_r[$past(rn_hi)] == {8'h00, $past(ir_r[7:0])})
		else $error("short immediate not zero filled");
	a_flags_keep: assert property ( // [RULE_23]
		exec_w && (is_mov || is_ldb || is_jmp || is_ldc) |=> t_r == $past(t_r) && v_r == $past(v_r))
		else $error("unnamed flag changed");
	a_dec_overflow: assert property ( // [RULE_04]
		exec_w && (is_decrement_carry_op || is_dt) |=> v_r == ($past(alu_opnd_w) == 16'h8000 && !($past(is_decrement_carry_op) && $past(t_r))))
		else $error("decrement overflow flag wrong");
endmodule
`default_nettype wire

// >>> src/cjlx_pkg.sv
// Shared constants, opcode patterns and state encoding for the execution core
package cjlx_pkg;
	// Widths and register file shape
	localparam int unsigned DATA_W = 16;
	localparam int unsigned ADDR_W = 22;
	localparam int unsigned EXT_W = 6;
	localparam int unsigned NUM_GPR = 16;
	localparam int unsigned NUM_AREG = 8;
	// Fixed register roles
	localparam logic [2:0] LINK_AREG = 3'h6;
	localparam logic [2:0] BASE8_AREG = 3'h0;
	localparam logic [3:0] REG_ZERO = 4'h0;
	localparam logic [3:0] ZREG_LO = 4'h6;
	localparam logic [3:0] ZREG_HI = 4'h7;
	// Program counter stepping and reset value
	localparam logic [ADDR_W-1:0] INSTR_BYTES = 22'h000002;
	localparam logic [ADDR_W-1:0] RESET_PC = 22'h000000;
	// Opcode masks and match values
	localparam logic [15:0] OPM_COM = 16'hffc0;
	localparam logic [15:0] OPV_COM = 16'h8900;
	localparam logic [15:0] OPM_ONE = 16'hfff0;
	localparam logic [15:0] OPV_DECREMENT_CARRY_OP = 16'h8940;
	localparam logic [15:0] OPV_INCREMENT_CARRY_OP = 16'h8950;
	localparam logic [15:0] OPV_EXT = 16'h8960;
	localparam logic [15:0] OPV_DT = 16'h89e0;
	localparam logic [15:0] OPM_JMP = 16'hfef0;
	localparam logic [15:0] OPV_JMP = 16'h86e0;
	localparam logic [15:0] OPM_MOV = 16'hf0f0;
	localparam logic [15:0] OPV_MOV = 16'h80d0;
	localparam logic [15:0] OPM_MOVA = 16'hf8f8;
	localparam logic [15:0] OPV_MOVA = 16'ha818;
	localparam logic [15:0] OPM_REXT = 16'hf8f0;
	localparam logic [15:0] OPV_REXT = 16'ha010;
	localparam logic [15:0] OPM_LDI8 = 16'hf000;
	localparam logic [15:0] OPV_LDI8 = 16'hc000;
	localparam logic [15:0] OPM_LDI16 = 16'hf0ff;
	localparam logic [15:0] OPV_LDI16 = 16'h80c0;
	localparam logic [15:0] OPM_LDA22 = 16'hf1c0;
	localparam logic [15:0] OPV_LDA22 = 16'hb000;
	localparam logic [15:0] OPM_LDB_S = 16'he880;
	localparam logic [15:0] OPV_LDB_S = 16'h6000;
	localparam logic [15:0] OPV_LDB_X = 16'h6080;
	localparam logic [15:0] OPM_LDB_L = 16'hf8f0;
	localparam logic [15:0] OPV_LDB_L = 16'ha030;
	localparam logic [15:0] OPM_LDB_8 = 16'hfe00;
	localparam logic [15:0] OPV_LDB_8 = 16'hd000;
	localparam logic [15:0] OPM_LDC = 16'hf0f8;
	localparam logic [15:0] OPV_LDC = 16'ha000;
	// Complement and jump modes
	localparam logic [1:0] COM_INV = 2'h0;
	localparam logic [1:0] COM_NEG = 2'h1;
	localparam logic [1:0] COM_NEGC = 2'h2;
	localparam logic [1:0] JMP_IF_FALSE = 2'h0;
	localparam logic [1:0] JMP_IF_TRUE = 2'h1;
	localparam logic [1:0] JMP_ALWAYS = 2'h2;
	localparam logic [1:0] JMP_LINK = 2'h3;
	// Transfer direction bit
	localparam logic DIR_STORE = 1'b1;
	// Arithmetic unit operations
	localparam logic [2:0] ALU_COM = 3'h0;
	localparam logic [2:0] ALU_DECREMENT_CARRY_OP = 3'h1;
	localparam logic [2:0] ALU_DT = 3'h2;
	localparam logic [2:0] ALU_EXT = 3'h3;
	localparam logic [2:0] ALU_INCREMENT_CARRY_OP = 3'h4;
	// Sequencer states
	typedef enum logic [7:0] {
		ST_FETCH = 8'h01,
		ST_FWAIT = 8'h02,
		ST_DECODE = 8'h04,
		ST_XWAIT = 8'h08,
		ST_XCAP = 8'h10,
		ST_EXEC = 8'h20,
		ST_MWAIT = 8'h40,
		ST_MCAP = 8'h80
	} cjlx_state_t;
endpackage

// >>> src/cjlx_alu.sv
// Single-operand arithmetic unit with carry and overflow outputs
`timescale 1ns/1ps
`default_nettype none
module cjlx_alu import cjlx_pkg::*; (
	// Operation select
	input wire logic [2:0] op_in,
	input wire logic [1:0] com_mode_in,
	// Operand and incoming test flag
	input wire logic [DATA_W-1:0] opnd_in,
	input wire logic t_in,
	// Result and flags
	output logic [DATA_W-1:0] res_out,
	output logic t_out,
	output logic v_out
);
	logic [DATA_W:0] sum;
	logic [DATA_W-1:0] inv;

	assign inv = ~opnd_in;

	// One adder shared by all modes but sign-widen; the unused result bits fall out as carry
	always_comb begin
		sum = {1'b0, opnd_in};
		res_out = opnd_in;
		t_out = t_in;
		v_out = 1'b0;
		case (op_in)
			ALU_COM: begin
				case (com_mode_in)
					COM_NEG: sum = {1'b0, inv} + 17'h00001;
					COM_NEGC: sum = {1'b0, inv} + {16'h0000, t_in};
					default: sum = {1'b0, inv};
				endcase
				res_out = sum[DATA_W-1:0];
				// Plain inverse tests for zero, the adding modes keep the carry [RULE_02]
				t_out = (com_mode_in == COM_INV) ? (inv == 16'h0000) : sum[DATA_W];
			end
			ALU_DECREMENT_CARRY_OP: begin
				// Minus one plus test flag; only the most negative value can wrap to positive [RULE_04]
				sum = {1'b0, opnd_in} + 17'h0ffff + {16'h0000, t_in};
				res_out = sum[DATA_W-1:0];
				t_out = sum[DATA_W];
				v_out = opnd_in[DATA_W-1] & ~sum[DATA_W-1];
			end
			ALU_DT: begin
				sum = {1'b0, opnd_in} + 17'h0ffff;
				res_out = sum[DATA_W-1:0];
				t_out = (sum[DATA_W-1:0] == 16'h0000); // [RULE_05]
				v_out = opnd_in[DATA_W-1] & ~sum[DATA_W-1];
			end
			ALU_EXT: res_out = {{8{opnd_in[7]}}, opnd_in[7:0]}; // [RULE_06]
			ALU_INCREMENT_CARRY_OP: begin
				sum = {1'b0, opnd_in} + {16'h0000, t_in}; // [RULE_07]
				res_out = sum[DATA_W-1:0];
				t_out = sum[DATA_W];
				v_out = ~opnd_in[DATA_W-1] & sum[DATA_W-1];
			end
			default: res_out = opnd_in;
		endcase
	end
endmodule
`default_nettype wire

// >>> tb/tb_cjlx_core.sv
// Self-checking bench for the execution core: program and data memories modelled here
`timescale 1ns/1ps
`default_nettype none
module tb_cjlx_core;
	import cjlx_pkg::*;
	logic ref_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [DATA_W-1:0] pm_data_in = 16'h0000;
	logic [7:0] dm_rdata_in = 8'h00;
	logic [ADDR_W-1:0] pm_addr_out;
	logic [ADDR_W-1:0] dm_addr_out;
	logic [ADDR_W-1:0] pc_out;
	logic [7:0] dm_wdata_out;
	logic pm_rd_out, dm_rd_out, dm_wr_out, squash_out, retire_out;
	logic t_flag_out, v_flag_out, r6_zero_flag_out, r7_zero_flag_out;
	int fail_count = 0;
	int n_tests = 0;
	int cycles = 0;
	int squashes = 0;
	int retires = 0;
	logic [15:0] rom [256];
	logic [7:0] mem [256];
	// Each entry: store address, store byte, flags {t,v,z6,z7}, flag mask
	logic [37:0] expq [$];
	logic [37:0] e;
	logic [3:0] flags_w;
	// Address of each expected store instruction, in program order
	logic [21:0] pcq [$] = '{22'h000008, 22'h00000a, 22'h000018, 22'h000030, 22'h00003e, 22'h000044,
		22'h00004a, 22'h000050, 22'h000054, 22'h000058, 22'h00005e};
	// Program; words 17, 21 and 22 are stores that must never execute
	logic [15:0] prog [48] = '{16'hc600, 16'hc180, 16'h8961, 16'hc840, 16'h7103, 16'h7181, 16'h8901,
		16'h8917, 16'h82c0, 16'h7fff, 16'h8952, 16'h8921, 16'h7181, 16'h8bc0, 16'h0024, 16'h86eb,
		16'h86e3, 16'h7103, 16'h8cc0, 16'h002e, 16'h87ec, 16'h7103, 16'h7103, 16'h83de, 16'h7300,
		16'hc601, 16'hc702, 16'h89e7, 16'h89e6, 16'hc005, 16'hd010, 16'hd111, 16'ha530, 16'h0102,
		16'h7502, 16'hc980, 16'ha401, 16'h7401, 16'hb401, 16'h0050, 16'h7520, 16'h8946, 16'h7686, 16'had1a,
		16'h7554, 16'ha41d, 16'ha115, 16'h7153};

	cjlx_core uut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .pm_addr_out(pm_addr_out),
		.pm_rd_out(pm_rd_out), .pm_data_in(pm_data_in), .dm_addr_out(dm_addr_out), .dm_rd_out(dm_rd_out),
		.dm_wr_out(dm_wr_out), .dm_wdata_out(dm_wdata_out), .dm_rdata_in(dm_rdata_in), .pc_out(pc_out),
		.squash_out(squash_out), .retire_out(retire_out), .t_flag_out(t_flag_out), .v_flag_out(v_flag_out),
		.r6_zero_flag_out(r6_zero_flag_out), .r7_zero_flag_out(r7_zero_flag_out));

	// 200 MHz clock
	initial begin
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Program memory answers one cycle after the strobe; otherwise the bus toggles so stale words show
	always @(posedge ref_clk_in) begin
		pm_data_in <= pm_rd_out ? rom[pm_addr_out[8:1]] : ~pm_data_in;
	end

	// Data memory: byte read one cycle after the strobe, byte write on the strobe
	always @(posedge ref_clk_in) begin
		dm_rdata_in <= dm_rd_out ? mem[dm_addr_out[7:0]] : ~dm_rdata_in;
		if (dm_wr_out === 1'b1) begin
			mem[dm_addr_out[7:0]] <= dm_wdata_out;
		end
	end

	assign flags_w = {t_flag_out, v_flag_out, r6_zero_flag_out, r7_zero_flag_out};

	// Every store is matched against the next expected one, flags and instruction address included
	always @(posedge ref_clk_in) begin
		if (resetn_in && dm_wr_out === 1'b1) begin
			if (expq.size() == 0) begin
				check({10'h000, dm_addr_out}, 32'hffffffff);
			end else begin
				e = expq.pop_front();
				check({2'h0, dm_addr_out, dm_wdata_out}, {2'h0, e[37:8]});
				check({28'h0, flags_w & e[3:0]}, {28'h0, e[7:4] & e[3:0]});
				check({10'h000, pc_out}, {10'h000, pcq.pop_front()});
				// Retire is low during a store's memory cycle, so the count is settled here
				if (expq.size() == 0) begin
					check(retires, 32'd39);
				end
			end
		end
		if (resetn_in && squash_out === 1'b1) begin
			squashes++;
		end
		if (resetn_in && retire_out === 1'b1) begin
			retires++;
		end
	end

	// Hang guard: the program needs well under two hundred cycles
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			conclude();
		end
	end

	initial begin
		for (int i = 0; i < 256; i++) begin
			rom[i] = (i < 48) ? prog[i] : 16'h0000;
			mem[i] = i[7:0] ^ 8'ha5;
		end
		rom[64] = 16'h1234;
		expq.push_back({22'h000043, 8'h80, 4'h2, 4'hf});
		expq.push_back({22'h00ffc0, 8'h80, 4'h2, 4'hf});
		expq.push_back({22'h00ffc0, 8'h80, 4'h7, 4'hf});
		expq.push_back({22'h000040, 8'h2a, 4'h7, 4'hf});
		expq.push_back({22'h000051, 8'hf5, 4'ha, 4'hf});
		expq.push_back({22'h000042, 8'he7, 4'ha, 4'hf});
		expq.push_back({22'h000041, 8'h34, 4'ha, 4'hf});
		expq.push_back({22'h010050, 8'he7, 4'ha, 4'hf});
		expq.push_back({22'h000040, 8'h00, 4'ha, 4'hf});
		expq.push_back({22'h010054, 8'he7, 4'ha, 4'hf});
		expq.push_back({22'h340053, 8'h34, 4'ha, 4'hf});
		repeat (8) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		while (expq.size() != 0) begin
			@(posedge ref_clk_in);
		end
		repeat (10) @(posedge ref_clk_in);
		check(squashes, 32'd2);
		conclude();
	end
endmodule
`default_nettype wire
